// file: hw/rsq_pin_filter.sv
// reset pin synchroniser, low time counter and pulse classifier
// assumes the pin is a plain level; runs on hclk, cleared by hresetn only
`timescale 1ns/1ps
module rsq_pin_filter
    import rsq_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // raw pin and results
    input wire logic pin_i,
    output logic level_o,
    output logic low_detect_o,
    output logic [1:0] pulse_class_o
);

    logic sync1_q; // first stage, read only by sync2_q
    logic sync2_q; // synchronised level
    logic prev_q; // level one cycle back
    logic [CNT_W-1:0] low_cnt_q; // low time, saturating

    // two flop synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // count low cycles, restart when high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_q <= '0;
        end else if (sync2_q) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != CNT_MAX) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    // classify the pulse at its rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_class_o <= PCLASS_NONE;
        end else if (sync2_q && !prev_q) begin
            if (low_cnt_q > LONG_CNT) begin
                pulse_class_o <= PCLASS_LONG;
            end else if (low_cnt_q >= SYNC_MIN_CNT) begin
                pulse_class_o <= PCLASS_SHORT;
            end
        end
    end

    // low long enough to start a warm reset
    assign level_o = sync2_q;
    assign low_detect_o = !sync2_q && (low_cnt_q >= SYNC_MIN_CNT);

endmodule

// file: hw/rsq_pkg.sv
// constants, timing counts, register map and types of the reset sequencer
// assumes a single 20 MHz hclk; counts other than PD_SETTLE_CYC are derived from the half clock period
package rsq_pkg;

    // clock and half clock period, in picoseconds
    localparam int CLK_PERIOD_PS = 50000;
    localparam int TCL_PS = CLK_PERIOD_PS / 2;

    // documented times, in half clock periods
    localparam int SYNC_MIN_TCL = 4;
    localparam int ENTER_MAX_TCL = 12;
    localparam int SEQ_TCL = 1024;
    localparam int LATCH_DIV2_TCL = 6;
    localparam int LATCH_TCL = 8;
    localparam int LONG_TCL = 1032;

    // cycle counts: least times round up, longest times round down
    localparam int SYNC_MIN_CYC = (SYNC_MIN_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ENTER_CYC = (ENTER_MAX_TCL * TCL_PS) / CLK_PERIOD_PS;
    localparam int SEQ_CYC = (SEQ_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LATCH_DIV2_CYC = (LATCH_DIV2_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LATCH_CYC = (LATCH_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LONG_CYC = (LONG_TCL * TCL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // pulldown released this many cycles before the sequence end, so the pin settles
    localparam int PD_SETTLE_CYC = 4;

    // counter width and counter compare values
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] SYNC_MIN_CNT = CNT_W'(SYNC_MIN_CYC);
    localparam logic [CNT_W-1:0] LONG_CNT = CNT_W'(LONG_CYC);
    localparam logic [CNT_W-1:0] ENTER_LAST = CNT_W'(ENTER_CYC - 1);
    localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYC - 1);
    localparam logic [CNT_W-1:0] PD_OFF_CNT = CNT_W'(SEQ_CYC - PD_SETTLE_CYC);
    localparam logic [CNT_W-1:0] LATCH_DIV2_LAST = CNT_W'(LATCH_DIV2_CYC - 1);
    localparam logic [CNT_W-1:0] LATCH_LAST = CNT_W'(LATCH_CYC - 1);

    // register map, byte offsets
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] REG_CMD = 4'h4;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
    localparam logic [REG_AW-1:0] REG_CFG = 4'hC;

    // control register fields
    localparam int CTRL_BDRST_BIT = 5;
    localparam int CTRL_POWER_DOWN_CONFIGURATION_BIT_BIT = 6;

    // command keys in the low half of a command write
    localparam logic [15:0] SOFTWARE_RESET_INSTRUCTION_KEY = 16'h5AA5;
    localparam logic [15:0] END_OF_INITIALIZATION_INSTRUCTION_KEY = 16'hC33C;

    // status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_CAUSE_LSB = 4;
    localparam int STAT_RESET_OUTPUT_PIN_BIT = 7;
    localparam int STAT_PCLASS_LSB = 8;

    // configuration port and its partial relatch fields
    localparam int CFG_W = 16;
    localparam int CFG_KEEP_HI = 12;
    localparam int CFG_KEEP_LO = 8;
    localparam int CFG_CLR_HI = 7;
    localparam int CFG_CLR_LO = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

    // first fetch address, segment 0 offset 0
    localparam logic [23:0] FETCH_START_ADDR = 24'h000000;

    // reset pulse classes
    localparam logic [1:0] PCLASS_NONE = 2'h0;
    localparam logic [1:0] PCLASS_SHORT = 2'h1;
    localparam logic [1:0] PCLASS_LONG = 2'h2;

    // sequencer states
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WDRAIN,
        ST_ENTER,
        ST_SEQ,
        ST_EXTEND,
        ST_LATCH
    } rsq_state_t;

    // reset causes
    typedef enum logic [1:0] {
        CAUSE_ASYNC,
        CAUSE_SYNC,
        CAUSE_SW,
        CAUSE_WDT
    } rsq_cause_t;

endpackage

// file: hw/rsq_sequencer.sv
// What this block does
// - pin low with vpp low resets at once
// - async reset: outputs safe, bus abort, pullups
// - on exit latch config, strobes inactive
// - restart fetch at address zero, segment zero
// - latch after 3 or 4 cycles
// - warm reset: drain within six cycles
// - pulldown only if enable bit; reset clears it
// - sequence 512 cycles, extend while pin low
// - vpp falling during warm reset goes async
// - keyed software reset command starts sequence
// - software reset relatches bits 12..8 only
// - watchdog overflow starts the reset sequence
// - watchdog: finish bus cycle unless ready high
// - watchdog reset relatches bits 12..8 only
// - pulldown signals warm, watchdog, software resets
// - reset output held low until end of init
// - power down bit enables vpp pullup
// - classify pulses short or long
//
// reset sequencer top with its ahb-lite register slave
// assumes one 20 MHz hclk, strap pll_bypass_div2_i stable, single word transfers
`timescale 1ns/1ps
module rsq_sequencer
    import rsq_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // reset pins
    input wire logic reset_input_pin_i,
    output logic reset_input_pin_o,
    output logic reset_input_pin_oe,
    input wire logic vpp_pin_i,
    output logic vpp_pullup_o,
    output logic reset_output_pin_o,
    // configuration port
    input wire logic [CFG_W-1:0] configuration_port_i,
    output logic configuration_port_pullup_o,
    output logic [CFG_W-1:0] config_latched_o,
    input wire logic pll_bypass_div2_i,
    // watchdog and bus status
    input wire logic wdt_overflow_i,
    input wire logic bus_cycle_active_i,
    input wire logic bus_uses_ready_i,
    input wire logic bus_wait_done_i,
    input wire logic ready_n_i,
    input wire logic int_access_busy_i,
    // core side strobes
    input wire logic core_ale_i,
    input wire logic core_rd_n_i,
    input wire logic core_wr_n_i,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    // core control
    output logic core_reset_o,
    output logic hold_cancel_o,
    output logic io_tristate_o,
    output logic bus_abort_o,
    output logic fetch_start_o,
    output logic [23:0] fetch_addr_o
);

    // async reset: board reset, or pin low while vpp low
    logic arst_n;
    assign arst_n = hresetn & (reset_input_pin_i | vpp_pin_i);

    // sequencer state
    rsq_state_t state_q; // current state
    logic [CNT_W-1:0] cnt_q; // per state cycle count
    rsq_cause_t cause_q; // why the last reset started
    logic reset_output_pin_q; // reset output level
    logic abort_q; // bus abort request
    logic vpp_pu_q; // vpp pullup enable
    logic fetch_q; // restart pulse
    logic [23:0] fetch_addr_q; // restart address
    logic [CFG_W-1:0] cfg_q; // latched configuration
    logic bidirectional_reset_enable_q; // bidirectional reset enable
    logic power_down_configuration_bit_q; // power down configuration bit

    // pin filter results
    logic pin_level; // synchronised pin
    logic pin_low_detect; // warm reset request
    logic [1:0] pulse_class; // last pulse class

    // bus side
    logic ap_valid_q; // data phase pending
    logic ap_write_q; // pending is a write
    logic [REG_AW-1:0] ap_addr_q; // pending offset
    logic ap_hit_q; // pending had upper address bits zero
    logic [31:0] rdata_q; // read data
    logic [31:0] rd_word; // read mux
    logic wr_cmd; // command write this cycle
    logic software_reset_instruction_cmd; // keyed software reset
    logic end_of_initialization_instruction_cmd; // end of initialisation
    logic addr_hit; // address within map

    // decoded helpers
    logic in_reset; // drivers off, holds cancelled
    logic latch_done; // last latch cycle
    logic [CNT_W-1:0] latch_last; // latch delay for this strap
    logic trigger; // a reset starts from run
    logic in_latch; // latch state, for the port pullup and checks

    // pin synchroniser and pulse measurement
    rsq_pin_filter u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_i(reset_input_pin_i),
        .level_o(pin_level),
        .low_detect_o(pin_low_detect),
        .pulse_class_o(pulse_class)
    );

    // combinational decode
    assign latch_last = pll_bypass_div2_i ? LATCH_DIV2_LAST : LATCH_LAST;
    assign latch_done = (state_q == ST_LATCH) && (cnt_q == latch_last);
    assign trigger = (state_q == ST_RUN) && (pin_low_detect || wdt_overflow_i || software_reset_instruction_cmd);
    assign in_reset = (state_q != ST_RUN) && (state_q != ST_WDRAIN);
    assign in_latch = (state_q == ST_LATCH);

    // state machine; async reset leaves it waiting to latch
    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_LATCH;
            cnt_q <= '0;
            cause_q <= CAUSE_ASYNC;
        end else begin
            unique case (state_q)
                // normal running: watch for reset sources
                ST_RUN: begin
                    cnt_q <= '0;
                    if (pin_low_detect) begin
                        state_q <= ST_ENTER;
                        cause_q <= CAUSE_SYNC;
                    end else if (wdt_overflow_i) begin
                        state_q <= ST_WDRAIN;
                        cause_q <= CAUSE_WDT;
                    end else if (software_reset_instruction_cmd) begin
                        state_q <= ST_ENTER;
                        cause_q <= CAUSE_SW;
                    end
                end
                // watchdog: let the bus cycle finish or abort it
                ST_WDRAIN: begin
                    if (!bus_cycle_active_i) begin
                        state_q <= ST_ENTER;
                    end else if (bus_wait_done_i && bus_uses_ready_i && ready_n_i) begin
                        state_q <= ST_ENTER;
                    end
                end
                // drain internal access, bounded
                ST_ENTER: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (!int_access_busy_i || (cnt_q == ENTER_LAST)) begin
                        state_q <= ST_SEQ;
                        cnt_q <= '0;
                    end
                end
                // fixed internal sequence, then sample the pin
                ST_SEQ: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == SEQ_LAST) begin
                        cnt_q <= '0;
                        state_q <= pin_level ? ST_LATCH : ST_EXTEND;
                    end
                end
                // extended while the pin stays low
                ST_EXTEND: begin
                    cnt_q <= '0;
                    if (pin_level) begin
                        state_q <= ST_LATCH;
                    end
                end
                // delay from rising edge to configuration latch
                ST_LATCH: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (latch_done) begin
                        state_q <= ST_RUN;
                        cnt_q <= '0;
                    end
                end
                default: begin
                    state_q <= ST_LATCH;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // reset output: low from any reset until end of init
    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            reset_output_pin_q <= 1'b0;
        end else if (trigger) begin
            reset_output_pin_q <= 1'b0;
        end else if (end_of_initialization_instruction_cmd && (state_q == ST_RUN)) begin
            reset_output_pin_q <= 1'b1;
        end
    end

    // bus abort request, held until restart
    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            abort_q <= 1'b1;
        end else if ((state_q == ST_RUN) && !wdt_overflow_i && trigger) begin
            abort_q <= 1'b1;
        end else if ((state_q == ST_WDRAIN) && bus_cycle_active_i && bus_wait_done_i
                     && bus_uses_ready_i && ready_n_i) begin
            abort_q <= 1'b1;
        end else if (latch_done) begin
            abort_q <= 1'b0;
        end
    end

    // restart pulse, fetch address and vpp pullup
    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_q <= 1'b0;
            fetch_addr_q <= FETCH_START_ADDR;
            vpp_pu_q <= 1'b0;
        end else begin
            fetch_q <= latch_done;
            if (latch_done) begin
                fetch_addr_q <= FETCH_START_ADDR;
                vpp_pu_q <= power_down_configuration_bit_q;
            end else if (trigger) begin
                vpp_pu_q <= 1'b0;
            end
        end
    end

    // configuration latch: full, or partial after software and watchdog
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= CFG_RESET;
        end else if (latch_done) begin
            if ((cause_q == CAUSE_SW) || (cause_q == CAUSE_WDT)) begin
                cfg_q[CFG_KEEP_HI:CFG_KEEP_LO] <= configuration_port_i[CFG_KEEP_HI:CFG_KEEP_LO];
                cfg_q[CFG_CLR_HI:CFG_CLR_LO] <= '0;
            end else begin
                cfg_q <= configuration_port_i;
            end
        end
    end

    // control bits: software sets, every completed reset clears enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bidirectional_reset_enable_q <= 1'b0;
            power_down_configuration_bit_q <= 1'b0;
        end else if (latch_done) begin
            bidirectional_reset_enable_q <= 1'b0;
        end else if (wr_cmd == 1'b0 && ap_valid_q && ap_write_q && addr_hit
                     && (ap_addr_q == REG_CTRL)) begin
            bidirectional_reset_enable_q <= hwdata[CTRL_BDRST_BIT];
            power_down_configuration_bit_q <= hwdata[CTRL_POWER_DOWN_CONFIGURATION_BIT_BIT];
        end
    end

    // ahb address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= '0;
            ap_hit_q <= 1'b0;
            rdata_q <= '0;
        end else if (hready) begin
            ap_valid_q <= hsel && htrans[1];
            ap_write_q <= hwrite;
            ap_addr_q <= haddr[REG_AW-1:0];
            ap_hit_q <= (haddr[31:REG_AW] == '0);
            rdata_q <= (hsel && htrans[1] && !hwrite && (haddr[31:REG_AW] == '0)) ? rd_word : '0;
        end
    end

    // read mux for the offset in the address phase
    always_comb begin
        rd_word = '0;
        unique case (haddr[REG_AW-1:0])
            REG_CTRL: begin
                rd_word[CTRL_BDRST_BIT] = bidirectional_reset_enable_q;
                rd_word[CTRL_POWER_DOWN_CONFIGURATION_BIT_BIT] = power_down_configuration_bit_q;
            end
            REG_STATUS: begin
                rd_word[STAT_STATE_LSB +: 3] = state_q;
                rd_word[STAT_CAUSE_LSB +: 2] = cause_q;
                rd_word[STAT_RESET_OUTPUT_PIN_BIT] = reset_output_pin_q;
                rd_word[STAT_PCLASS_LSB +: 2] = pulse_class;
            end
            REG_CFG: begin
                rd_word[CFG_W-1:0] = cfg_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // data phase write decode; upper address bits must be zero
    assign addr_hit = ap_hit_q;
    assign wr_cmd = ap_valid_q && ap_write_q && addr_hit && (ap_addr_q == REG_CMD);
    assign software_reset_instruction_cmd = wr_cmd && (hwdata[15:0] == SOFTWARE_RESET_INSTRUCTION_KEY);
    assign end_of_initialization_instruction_cmd = wr_cmd && (hwdata[15:0] == END_OF_INITIALIZATION_INSTRUCTION_KEY);

    // bus outputs: zero wait, always okay
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // pin and core outputs
    assign reset_output_pin_o = reset_output_pin_q;
    assign reset_input_pin_o = 1'b0;
    assign reset_input_pin_oe = bidirectional_reset_enable_q && (cause_q != CAUSE_ASYNC)
        && ((state_q == ST_ENTER) || ((state_q == ST_SEQ) && (cnt_q < PD_OFF_CNT)));
    assign vpp_pullup_o = vpp_pu_q;
    assign configuration_port_pullup_o = in_latch && (cause_q == CAUSE_ASYNC);
    assign config_latched_o = cfg_q;
    assign ale_o = in_reset ? 1'b0 : core_ale_i;
    assign rd_n_o = in_reset ? 1'b1 : core_rd_n_i;
    assign wr_n_o = in_reset ? 1'b1 : core_wr_n_i;
    assign core_reset_o = (state_q != ST_RUN);
    assign hold_cancel_o = in_reset;
    assign io_tristate_o = in_reset;
    assign bus_abort_o = abort_q;
    assign fetch_start_o = fetch_q;
    assign fetch_addr_o = fetch_addr_q;

    // checks
    localparam int A_ENTER_MAX = 6;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_async_now;
        (!reset_input_pin_i && !vpp_pin_i) |-> core_reset_o && !reset_output_pin_o && io_tristate_o;
    endproperty
    a_async_now: assert property (p_async_now) else $error("async reset not immediate");

    property p_enter_bound;
        (state_q == ST_ENTER) |-> ##[1:A_ENTER_MAX] (state_q != ST_ENTER);
    endproperty
    a_enter_bound: assert property (p_enter_bound) else $error("drain too long");

    property p_seq_len;
        (state_q == ST_SEQ && cnt_q != SEQ_LAST) |=> (state_q == ST_SEQ) || in_latch;
    endproperty
    a_seq_len: assert property (p_seq_len) else $error("sequence left early");

    property p_extend;
        $rose(state_q == ST_EXTEND) |-> $past(!pin_level);
    endproperty
    a_extend: assert property (p_extend) else $error("extended with pin high");

    property p_latch_time;
        (fetch_start_o && pll_bypass_div2_i && cause_q != CAUSE_ASYNC)
            |-> $past(in_latch, 3) && !$past(in_latch, 4);
    endproperty
    a_latch_time: assert property (p_latch_time) else $error("latch delay wrong");

    property p_restart;
        fetch_start_o |-> (fetch_addr_o == FETCH_START_ADDR) && !core_reset_o && !bus_abort_o;
    endproperty
    a_restart: assert property (p_restart) else $error("bad restart");

    property p_partial;
        (fetch_start_o && (cause_q == CAUSE_SW || cause_q == CAUSE_WDT))
            |-> config_latched_o[CFG_CLR_HI:CFG_CLR_LO] == '0;
    endproperty
    a_partial: assert property (p_partial) else $error("low config bits kept");

    property p_pd_enable;
        reset_input_pin_oe |-> bidirectional_reset_enable_q && (cause_q != CAUSE_ASYNC) && core_reset_o;
    endproperty
    a_pd_enable: assert property (p_pd_enable) else $error("pulldown without enable");

    property p_reset_output_pin;
        $rose(reset_output_pin_o) |-> $past(end_of_initialization_instruction_cmd) && !core_reset_o;
    endproperty
    a_reset_output_pin: assert property (p_reset_output_pin) else $error("reset output released early");

    property p_wdt_abort;
        (state_q == ST_WDRAIN && bus_cycle_active_i && bus_wait_done_i && bus_uses_ready_i
            && ready_n_i) |=> bus_abort_o && (state_q == ST_ENTER);
    endproperty
    a_wdt_abort: assert property (p_wdt_abort) else $error("watchdog abort missed");

    property p_vpp_pu;
        $rose(vpp_pullup_o) |-> $past(latch_done) && power_down_configuration_bit_q;
    endproperty
    a_vpp_pu: assert property (p_vpp_pu) else $error("vpp pullup wrong");

    property p_cov_sync;
        (state_q == ST_RUN && pin_low_detect) ##1 (state_q == ST_ENTER);
    endproperty
    c_cov_sync: cover property (p_cov_sync);

    property p_cov_sw;
        fetch_start_o && cause_q == CAUSE_SW;
    endproperty
    c_cov_sw: cover property (p_cov_sw);

    property p_cov_wdt;
        fetch_start_o && cause_q == CAUSE_WDT;
    endproperty
    c_cov_wdt: cover property (p_cov_wdt);

    property p_cov_extend;
        (state_q == ST_EXTEND) ##1 in_latch;
    endproperty
    c_cov_extend: cover property (p_cov_extend);

endmodule

// file: test/rsq_reset_ext.sv
// external reset circuit: pin pullup, wired-low button, vpp supervisor
// assumes pulldown_oe is high while the sequencer pulls the pin low
`timescale 1ns/1ps
module rsq_reset_ext (
    // sequencer side
    input wire logic pulldown_oe,
    // button and supply supervisor
    input wire logic ext_low,
    input wire logic ext_vpp_low,
    // resolved pin levels
    output logic pin_level,
    output logic vpp_level
);
    // pullup wins unless a party pulls low
    assign pin_level = ~(pulldown_oe | ext_low);
    assign vpp_level = ~ext_vpp_low;
endmodule

// file: test/rsq_sequencer_tb.sv
// bench: register table, then software, warm, watchdog and async resets
// assumes zero-wait bus answers and the external circuit model
`timescale 1ns/1ps
module rsq_sequencer_tb
    import rsq_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic [CFG_W-1:0] port_val = 16'h1F3C;
    logic ext_low = 1'b0;
    logic vpp_low = 1'b0;
    logic wdt_q = 1'b0;
    logic [3:0] bus_st = 4'h0; // active, uses ready, wait done, ready_n
    logic [2:0] core_strb = 3'b100; // core drives ale high, rd/wr low
    logic [2:0] strb;
    logic hreadyout, pin_oe, pin_lvl, vpp_lvl, reset_output_pin, core_rst, tri_on, abort, fetch_start;
    logic [23:0] fetch_addr;
    logic vpp_pu, cfg_pu, hold;
    logic busy = 1'b0; // internal access running
    logic div2 = 1'b0; // pll bypass with prescaler strap
    int errors = 0;
    int cmp_count = 0;
    // register table rows: address and value after power-on
    logic [31:0] row_a [4] = '{32'h0, 32'h8, 32'hC, 32'h10};
    logic [31:0] row_e [4] = '{32'h0, 32'h0, 32'h1F3C, 32'h0};

    always #25 hclk = ~hclk;

    rsq_sequencer dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .reset_input_pin_i(pin_lvl), .reset_input_pin_o(),
        .reset_input_pin_oe(pin_oe), .vpp_pin_i(vpp_lvl), .vpp_pullup_o(vpp_pu),
        .reset_output_pin_o(reset_output_pin), .configuration_port_i(port_val),
        .configuration_port_pullup_o(cfg_pu), .config_latched_o(), .pll_bypass_div2_i(div2),
        .wdt_overflow_i(wdt_q), .bus_cycle_active_i(bus_st[3]), .bus_uses_ready_i(bus_st[2]),
        .bus_wait_done_i(bus_st[1]), .ready_n_i(bus_st[0]), .int_access_busy_i(busy),
        .core_ale_i(core_strb[2]), .core_rd_n_i(core_strb[1]), .core_wr_n_i(core_strb[0]),
        .ale_o(strb[2]), .rd_n_o(strb[1]), .wr_n_o(strb[0]), .core_reset_o(core_rst),
        .hold_cancel_o(hold), .io_tristate_o(tri_on), .bus_abort_o(abort),
        .fetch_start_o(fetch_start), .fetch_addr_o(fetch_addr)
    );

    rsq_reset_ext ext (.pulldown_oe(pin_oe), .ext_low(ext_low), .ext_vpp_low(vpp_low),
        .pin_level(pin_lvl), .vpp_level(vpp_lvl));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // bounded wait for the restart pulse, then realign to a rising edge
    task automatic wait_fetch();
        int n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (fetch_start !== 1'b1 && n < 3000);
        chk({7'h0, fetch_start, fetch_addr}, {8'h1, FETCH_START_ADDR});
        @(posedge hclk);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, well beyond four full sequences
    initial begin
        #400000;
        errors++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        wait_fetch();
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, row_a[i], 32'h0);
            chk(rd, row_e[i]);
        end
        // software reset with the pulldown enabled and a new strap value
        bus(1'b1, 32'(REG_CTRL), 32'h60);
        port_val <= 16'h0AC3;
        bus(1'b1, 32'(REG_CMD), {16'h0, SOFTWARE_RESET_INSTRUCTION_KEY});
        repeat (4) @(negedge hclk);
        chk({30'h0, pin_oe, reset_output_pin}, 32'h2);
        wait_fetch();
        bus(1'b0, 32'(REG_CFG), 32'h0);
        chk(rd & 32'h1FFC, 32'h0A00);
        bus(1'b0, 32'(REG_STATUS), 32'h0);
        chk(rd & 32'h330, 32'h120);
        bus(1'b0, 32'(REG_CTRL), 32'h0);
        chk(rd, 32'h40);
        chk({31'h0, vpp_pu}, 32'h1);
        bus(1'b1, 32'(REG_CMD), {16'h0, END_OF_INITIALIZATION_INSTRUCTION_KEY});
        @(negedge hclk);
        chk({31'h0, reset_output_pin}, 32'h1);
        // warm reset: long low pulse, internal access busy, pulldown disabled
        @(posedge hclk);
        ext_low <= 1'b1;
        busy <= 1'b1;
        repeat (600) @(posedge hclk);
        ext_low <= 1'b0;
        busy <= 1'b0;
        repeat (4) @(negedge hclk);
        chk({29'h0, core_rst, reset_output_pin, pin_oe}, 32'h4);
        wait_fetch();
        bus(1'b0, 32'(REG_STATUS), 32'h0);
        chk(rd, 32'h210);
        // watchdog overflow while a ready cycle is pending with ready high
        bus_st <= 4'hF;
        div2 <= 1'b1;
        wdt_q <= 1'b1;
        @(posedge hclk);
        wdt_q <= 1'b0;
        repeat (3) @(negedge hclk);
        chk({31'h0, abort}, 32'h1);
        @(posedge hclk) bus_st <= 4'h0;
        wait_fetch();
        bus(1'b0, 32'(REG_STATUS), 32'h0);
        chk(rd & 32'h30, 32'h30);
        // async reset acts without a clock edge
        ext_low <= 1'b1;
        vpp_low <= 1'b1;
        #5;
        chk({24'h0, cfg_pu, hold, core_rst, tri_on, reset_output_pin, strb}, 32'hF3);
        @(posedge hclk);
        ext_low <= 1'b0;
        vpp_low <= 1'b0;
        wait_fetch();
        bus(1'b0, 32'(REG_STATUS), 32'h0);
        chk(rd & 32'hB7, 32'h0);
        print_verdict();
    end
endmodule
